// File: tcc_pkg.sv
// Shared constants and types for the timer compare, control and status block.
package tcc_pkg;

    // ========================================================================
    // Register map (byte addresses on the internal register bus)
    // ========================================================================
    localparam logic [7:0] TCC_ADDR_CONTROL = 8'h12;
    localparam logic [7:0] TCC_ADDR_STATUS = 8'h13;
    localparam logic [7:0] TCC_ADDR_CAP_HIGH = 8'h14;
    localparam logic [7:0] TCC_ADDR_CAP_LOW = 8'h15;
    localparam logic [7:0] TCC_ADDR_CMP_HIGH = 8'h16;
    localparam logic [7:0] TCC_ADDR_CMP_LOW = 8'h17;
    localparam logic [7:0] TCC_ADDR_CNT_HIGH = 8'h18;
    localparam logic [7:0] TCC_ADDR_CNT_LOW = 8'h19;

    // ========================================================================
    // Field positions
    // ========================================================================
    localparam int TCC_CTL_CAP_IE_BIT = 7;
    localparam int TCC_CTL_CMP_IE_BIT = 6;
    localparam int TCC_CTL_ROLL_IE_BIT = 5;
    localparam int TCC_CTL_EDGE_BIT = 1;
    localparam int TCC_CTL_LEVEL_BIT = 0;
    // Status flags sit in bits 7..5: capture, compare, rollover.
    localparam int TCC_STS_FLAG_LSB = 5;
    localparam int TCC_FLAG_ROLL = 0;
    localparam int TCC_FLAG_CMP = 1;
    localparam int TCC_FLAG_CAP = 2;

    // ========================================================================
    // Reset values and timing
    // ========================================================================
    localparam logic [15:0] TCC_CNT_RESET = 16'hFFFC;
    localparam logic [15:0] TCC_CNT_ALL_ONES = 16'hFFFF;
    localparam logic [7:0] TCC_RD_IDLE = 8'h00;
    localparam int TCC_PRESCALE_DIV = 4;
    localparam logic [1:0] TCC_PRE_LAST = 2'(TCC_PRESCALE_DIV - 1);

    // ========================================================================
    // Types
    // ========================================================================
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wr_data;
        logic wr_stb;
        logic rd_stb;
    } tcc_bus_s;

    typedef struct packed {
        logic capture_irq_enable;
        logic compare_irq_enable;
        logic rollover_irq_enable;
        logic compare_output_level;
    } tcc_ctl_s;

endpackage

// File: tcc_timer.sv
// Timer counter with output compare, input capture, control and status registers.
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
`default_nettype none

// How it works
// RQ1 - Compare once per counter tick
// RQ2 - Match drives compare pin to level bit
// RQ3 - Compare registers read/write, reset never touches
// RQ4 - High write inhibits compares until low write
// RQ5 - Match flag cleared by status read, low access
// RQ6 - Level latched every match regardless of flag
// RQ7 - Software masks, writes high, reads status, writes low
// RQ8 - Reset clears control except edge select
// RQ9 - Capture enable gates capture interrupt
// RQ10 - Compare enable gates compare interrupt
// RQ11 - Rollover enable gates rollover interrupt
// RQ12 - Edge select picks rising or falling
// RQ13 - Software selects rising edge for comparator
// RQ14 - Level one drives high, zero low
// RQ15 - Status writes ignored, reset keeps flags
// RQ16 - Capture flag cleared by status, captured-low read
// RQ17 - Rollover flag cleared by status, counter-low read
// RQ18 - Wait mode keeps timer and interrupts running
// RQ19 - Stop freezes counter, reset reloads count
// RQ20 - Edge in stop arms, shows after wakeup
// RQ21 - Halt behaves exactly like wait
// RQ22 - Counter advances every four bus clocks
// RQ23 - Captured value is one above counter
// RQ24 - Interrupt while any enabled flag set

module tcc_timer (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // Register bus
    input wire tcc_pkg::tcc_bus_s bus_req,
    output logic [7:0] rd_data,
    // Power modes
    input wire logic stop_mode,
    // Capture sources
    input wire logic capture_input_pin,
    input wire logic comparator_two_flag,
    input wire logic capture_source_select,
    // Outputs
    output logic compare_output_pin,
    output logic timer_irq
);

    // ========================================================================
    // Declarations
    // ========================================================================
    logic [1:0] pre_ff;
    logic [15:0] cnt_ff, cap_val_ff;
    logic [7:0] cmp_hi_ff, cmp_lo_ff, cnt_lo_latch_ff, rd_data_ff;
    logic [2:0] flags_ff, arm_ff, cap_warm_ff;
    tcc_pkg::tcc_ctl_s ctl_ff;
    logic tick_ff, cmp_inhibit_ff, edge_sel_ff, cap_pin_s1_ff, cap_pin_s2_ff, cap_prev_ff;
    logic cap_armed_ff, cap_hold_ff, cnt_latched_ff, compare_pin_ff, timer_irq_ff;

    logic wr_ctl, wr_cmp_hi, wr_cmp_lo;
    logic rd_sts, rd_cap_hi, rd_cap_lo, rd_cnt_hi, rd_cnt_lo, acc_cmp_lo;
    logic pre_wrap, roll_evt, cmp_evt, cap_src, cap_edge, cap_evt;
    logic [2:0] set_vec, clr_vec, en_vec;
    logic [7:0] nxt_rd_data;

    // ========================================================================
    // Address decode
    // ========================================================================
    assign wr_ctl = bus_req.wr_stb && (bus_req.addr == tcc_pkg::TCC_ADDR_CONTROL);
    assign wr_cmp_hi = bus_req.wr_stb && (bus_req.addr == tcc_pkg::TCC_ADDR_CMP_HIGH);
    assign wr_cmp_lo = bus_req.wr_stb && (bus_req.addr == tcc_pkg::TCC_ADDR_CMP_LOW);
    assign rd_sts = bus_req.rd_stb && (bus_req.addr == tcc_pkg::TCC_ADDR_STATUS);
    assign rd_cap_hi = bus_req.rd_stb && (bus_req.addr == tcc_pkg::TCC_ADDR_CAP_HIGH);
    assign rd_cap_lo = bus_req.rd_stb && (bus_req.addr == tcc_pkg::TCC_ADDR_CAP_LOW);
    assign rd_cnt_hi = bus_req.rd_stb && (bus_req.addr == tcc_pkg::TCC_ADDR_CNT_HIGH);
    assign rd_cnt_lo = bus_req.rd_stb && (bus_req.addr == tcc_pkg::TCC_ADDR_CNT_LOW);
    assign acc_cmp_lo = wr_cmp_lo || (bus_req.rd_stb && (bus_req.addr == tcc_pkg::TCC_ADDR_CMP_LOW));

    // ========================================================================
    // Prescaler and free-running counter
    // ========================================================================
    // Wait and halt need no handling: only stop freezes the timer.
    assign pre_wrap = !stop_mode && (pre_ff == tcc_pkg::TCC_PRE_LAST);
    assign roll_evt = pre_wrap && (cnt_ff == tcc_pkg::TCC_CNT_ALL_ONES);

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            pre_ff <= 2'h0;
            cnt_ff <= tcc_pkg::TCC_CNT_RESET; // RQ19
            tick_ff <= 1'b0;
        end else begin
            tick_ff <= pre_wrap; // RQ1
            if (!stop_mode) begin // RQ19 RQ18 RQ21
                pre_ff <= pre_ff + 2'h1; // RQ22
                if (pre_wrap) begin
                    cnt_ff <= cnt_ff + 16'h0001;
                end
            end
        end
    end

    // ========================================================================
    // Compare registers
    // ========================================================================
    // No reset on purpose: the compare value survives every reset.
    always_ff @(posedge clk_sys) begin
        if (wr_cmp_hi) begin
            cmp_hi_ff <= bus_req.wr_data; // RQ3
        end
        if (wr_cmp_lo) begin
            cmp_lo_ff <= bus_req.wr_data; // RQ3
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            cmp_inhibit_ff <= 1'b0;
        end else if (wr_cmp_lo) begin
            cmp_inhibit_ff <= 1'b0; // RQ4
        end else if (wr_cmp_hi) begin
            cmp_inhibit_ff <= 1'b1; // RQ4
        end
    end

    // The comparison looks at the counter value just after it has advanced.
    assign cmp_evt = tick_ff && !cmp_inhibit_ff && (cnt_ff == {cmp_hi_ff, cmp_lo_ff}); // RQ1 RQ4

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            compare_pin_ff <= 1'b0;
        end else if (cmp_evt) begin
            compare_pin_ff <= ctl_ff.compare_output_level; // RQ2 RQ6 RQ14
        end
    end

    // ========================================================================
    // Control register
    // ========================================================================
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ctl_ff <= '0; // RQ8
        end else if (wr_ctl) begin
            ctl_ff.capture_irq_enable <= bus_req.wr_data[tcc_pkg::TCC_CTL_CAP_IE_BIT];
            ctl_ff.compare_irq_enable <= bus_req.wr_data[tcc_pkg::TCC_CTL_CMP_IE_BIT];
            ctl_ff.rollover_irq_enable <= bus_req.wr_data[tcc_pkg::TCC_CTL_ROLL_IE_BIT];
            ctl_ff.compare_output_level <= bus_req.wr_data[tcc_pkg::TCC_CTL_LEVEL_BIT];
        end
    end

    // Edge select keeps its value across resets, so it has no reset branch.
    always_ff @(posedge clk_sys) begin
        if (wr_ctl) begin
            edge_sel_ff <= bus_req.wr_data[tcc_pkg::TCC_CTL_EDGE_BIT]; // RQ8
        end
    end

    // ========================================================================
    // Input capture
    // ========================================================================
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            cap_pin_s1_ff <= 1'b0;
            cap_pin_s2_ff <= 1'b0;
            cap_prev_ff <= 1'b0;
            cap_warm_ff <= 3'h0;
        end else begin
            cap_pin_s1_ff <= capture_input_pin;
            cap_pin_s2_ff <= cap_pin_s1_ff;
            cap_prev_ff <= cap_src;
            cap_warm_ff <= {cap_warm_ff[1:0], 1'b1};
        end
    end

    assign cap_src = capture_source_select ? comparator_two_flag : cap_pin_s2_ff; // RQ9
    // A source already high at reset release must not look like an edge, so edges wait for real samples.
    assign cap_edge = cap_warm_ff[2] && (edge_sel_ff ? (cap_src && !cap_prev_ff) : (!cap_src && cap_prev_ff)); // RQ12
    // A capture is lost, not deferred, while the captured high byte is held.
    assign cap_evt = !stop_mode && !cap_hold_ff && (cap_edge || cap_armed_ff); // RQ20

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            cap_armed_ff <= 1'b0; // RQ20
        end else begin
            cap_armed_ff <= stop_mode && (cap_armed_ff || cap_edge); // RQ20
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            cap_hold_ff <= 1'b0;
        end else if (rd_cap_lo) begin
            cap_hold_ff <= 1'b0;
        end else if (rd_cap_hi) begin
            cap_hold_ff <= 1'b1;
        end
    end

    // Synchroniser delay is hidden by storing one count above the present value.
    always_ff @(posedge clk_sys) begin
        if (cap_evt) begin
            cap_val_ff <= cnt_ff + 16'h0001; // RQ23
        end
    end

    // ========================================================================
    // Counter low-byte latch
    // ========================================================================
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            cnt_latched_ff <= 1'b0;
            cnt_lo_latch_ff <= 8'h00;
        end else if (rd_cnt_lo) begin
            cnt_latched_ff <= 1'b0;
        end else if (rd_cnt_hi && !cnt_latched_ff) begin
            cnt_latched_ff <= 1'b1;
            cnt_lo_latch_ff <= cnt_ff[7:0];
        end
    end

    // ========================================================================
    // Status flags
    // ========================================================================
    assign set_vec[tcc_pkg::TCC_FLAG_ROLL] = roll_evt; // RQ17
    assign set_vec[tcc_pkg::TCC_FLAG_CMP] = cmp_evt; // RQ5
    assign set_vec[tcc_pkg::TCC_FLAG_CAP] = cap_evt; // RQ16
    assign clr_vec[tcc_pkg::TCC_FLAG_ROLL] = rd_cnt_lo;
    assign clr_vec[tcc_pkg::TCC_FLAG_CMP] = acc_cmp_lo;
    assign clr_vec[tcc_pkg::TCC_FLAG_CAP] = rd_cap_lo;
    assign en_vec[tcc_pkg::TCC_FLAG_ROLL] = ctl_ff.rollover_irq_enable;
    assign en_vec[tcc_pkg::TCC_FLAG_CMP] = ctl_ff.compare_irq_enable;
    assign en_vec[tcc_pkg::TCC_FLAG_CAP] = ctl_ff.capture_irq_enable;

    generate
        for (genvar i = 0; i < 3; i++) begin : g_flag
            // Flags have no reset and ignore bus writes; a set beats a clear.
            always_ff @(posedge clk_sys) begin
                if (set_vec[i]) begin
                    flags_ff[i] <= 1'b1; // RQ15
                end else if (clr_vec[i] && arm_ff[i]) begin
                    flags_ff[i] <= 1'b0; // RQ5 RQ16 RQ17
                end
            end

            always_ff @(posedge clk_sys or negedge rst_b) begin
                if (!rst_b) begin
                    arm_ff[i] <= 1'b0;
                end else if (rd_sts && flags_ff[i]) begin
                    arm_ff[i] <= 1'b1;
                end else if (clr_vec[i]) begin
                    arm_ff[i] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            timer_irq_ff <= 1'b0;
        end else begin
            timer_irq_ff <= |(flags_ff & en_vec); // RQ24 RQ9 RQ10 RQ11 RQ18
        end
    end

    // ========================================================================
    // Read data
    // ========================================================================
    always_comb begin
        nxt_rd_data = tcc_pkg::TCC_RD_IDLE;
        if (bus_req.rd_stb) begin
            unique case (bus_req.addr)
                tcc_pkg::TCC_ADDR_CONTROL: begin
                    nxt_rd_data[tcc_pkg::TCC_CTL_CAP_IE_BIT] = ctl_ff.capture_irq_enable;
                    nxt_rd_data[tcc_pkg::TCC_CTL_CMP_IE_BIT] = ctl_ff.compare_irq_enable;
                    nxt_rd_data[tcc_pkg::TCC_CTL_ROLL_IE_BIT] = ctl_ff.rollover_irq_enable;
                    nxt_rd_data[tcc_pkg::TCC_CTL_EDGE_BIT] = edge_sel_ff;
                    nxt_rd_data[tcc_pkg::TCC_CTL_LEVEL_BIT] = ctl_ff.compare_output_level;
                end
                tcc_pkg::TCC_ADDR_STATUS: begin
                    nxt_rd_data[tcc_pkg::TCC_STS_FLAG_LSB +: 3] = flags_ff;
                end
                tcc_pkg::TCC_ADDR_CAP_HIGH: nxt_rd_data = cap_val_ff[15:8];
                tcc_pkg::TCC_ADDR_CAP_LOW: nxt_rd_data = cap_val_ff[7:0];
                tcc_pkg::TCC_ADDR_CMP_HIGH: nxt_rd_data = cmp_hi_ff;
                tcc_pkg::TCC_ADDR_CMP_LOW: nxt_rd_data = cmp_lo_ff;
                tcc_pkg::TCC_ADDR_CNT_HIGH: nxt_rd_data = cnt_ff[15:8];
                tcc_pkg::TCC_ADDR_CNT_LOW: nxt_rd_data = cnt_latched_ff ? cnt_lo_latch_ff : cnt_ff[7:0];
                default: nxt_rd_data = tcc_pkg::TCC_RD_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rd_data_ff <= tcc_pkg::TCC_RD_IDLE;
        end else begin
            rd_data_ff <= nxt_rd_data;
        end
    end

    assign rd_data = rd_data_ff;
    assign compare_output_pin = compare_pin_ff;
    assign timer_irq = timer_irq_ff;

    // ========================================================================
    // Assertions
    // ========================================================================
    a_counter_prescale: assert property ( // RQ22
        @(posedge clk_sys) disable iff (!rst_b)
        (!stop_mode && pre_ff == tcc_pkg::TCC_PRE_LAST) |=> (cnt_ff == $past(cnt_ff) + 16'h0001) && tick_ff
    ) else $error("Counter did not advance at the end of the prescale period.");

    a_counter_hold: assert property ( // RQ22
        @(posedge clk_sys) disable iff (!rst_b)
        (pre_ff != tcc_pkg::TCC_PRE_LAST) |=> (cnt_ff == $past(cnt_ff)) && !tick_ff
    ) else $error("Counter moved between prescale ends.");

    a_stop_freeze: assert property ( // RQ19
        @(posedge clk_sys) disable iff (!rst_b)
        stop_mode [*2] |-> $stable(cnt_ff) && $stable(pre_ff)
    ) else $error("Counter moved during stop.");

    a_compare_pin_level: assert property ( // RQ2
        @(posedge clk_sys) disable iff (!rst_b)
        (tick_ff && !cmp_inhibit_ff && cnt_ff == {cmp_hi_ff, cmp_lo_ff})
        |=> compare_pin_ff == $past(ctl_ff.compare_output_level) && flags_ff[tcc_pkg::TCC_FLAG_CMP]
    ) else $error("Compare match did not drive level and flag.");

    a_compare_inhibit: assert property ( // RQ4
        @(posedge clk_sys) disable iff (!rst_b)
        (wr_cmp_hi && !wr_cmp_lo) |=> cmp_inhibit_ff && !cmp_evt
    ) else $error("Compare not inhibited after high byte write.");

    a_flag_clear_seq: assert property ( // RQ5
        @(posedge clk_sys) disable iff (!rst_b)
        (rd_sts && flags_ff[tcc_pkg::TCC_FLAG_CMP] && !cmp_evt) ##1 (acc_cmp_lo && !cmp_evt)
        |=> !flags_ff[tcc_pkg::TCC_FLAG_CMP]
    ) else $error("Compare flag survived its clearing sequence.");

    a_rollover_flag: assert property ( // RQ17
        @(posedge clk_sys) disable iff (!rst_b)
        (pre_wrap && cnt_ff == tcc_pkg::TCC_CNT_ALL_ONES) |=> flags_ff[tcc_pkg::TCC_FLAG_ROLL] && cnt_ff == 16'h0000
    ) else $error("Rollover flag not set on wrap.");

    a_capture_value: assert property ( // RQ23
        @(posedge clk_sys) disable iff (!rst_b)
        cap_evt |=> cap_val_ff == $past(cnt_ff) + 16'h0001 && flags_ff[tcc_pkg::TCC_FLAG_CAP]
    ) else $error("Captured value or flag wrong.");

    a_capture_in_stop: assert property ( // RQ20
        @(posedge clk_sys) disable iff (!rst_b)
        (stop_mode && !flags_ff[tcc_pkg::TCC_FLAG_CAP]) |=> !flags_ff[tcc_pkg::TCC_FLAG_CAP]
    ) else $error("Capture flag set while stopped.");

    a_irq_gate: assert property ( // RQ24
        @(posedge clk_sys) disable iff (!rst_b)
        (|(flags_ff & en_vec)) |=> timer_irq_ff
    ) else $error("Interrupt missing with an enabled flag set.");

    a_irq_quiet: assert property ( // RQ10
        @(posedge clk_sys) disable iff (!rst_b)
        (en_vec == 3'h0) |=> !timer_irq_ff
    ) else $error("Interrupt raised with all enables clear.");

endmodule

`default_nettype wire

// File: tcc_host.sv
// Host processor model that masters the timer's register bus.
`timescale 1ns/1ps
`default_nettype none

module tcc_host (
    // Clock
    input wire logic clk_sys,
    // Register bus
    output var tcc_pkg::tcc_bus_s bus_req,
    input wire logic [7:0] rd_data
);
    initial begin
        bus_req = '0;
    end

    // ========================================================================
    // Bus cycles
    // ========================================================================
    // Each cycle leaves one idle edge behind it, so two calls never drive a strobe twice in one step.
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk_sys);
        bus_req <= '{addr: a, wr_data: v, wr_stb: 1'b1, rd_stb: 1'b0};
        @(posedge clk_sys);
        bus_req.wr_stb <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so they are taken just after that edge.
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk_sys);
        bus_req <= '{addr: a, wr_data: 8'h00, wr_stb: 1'b0, rd_stb: 1'b1};
        @(posedge clk_sys);
        bus_req.rd_stb <= 1'b0;
        #1;
        v = rd_data;
    endtask
endmodule

`default_nettype wire

// File: tb_tcc_timer.sv
// Self-checking testbench for the timer compare, control and status block.
`timescale 1ns/1ps
`default_nettype none

module tb_tcc_timer;
    localparam int CYCLE_LIMIT = 3000;
    localparam logic [7:0] A_CTL = tcc_pkg::TCC_ADDR_CONTROL;
    localparam logic [7:0] A_STS = tcc_pkg::TCC_ADDR_STATUS;
    localparam logic [7:0] A_CAPH = tcc_pkg::TCC_ADDR_CAP_HIGH;
    localparam logic [7:0] A_CAPL = tcc_pkg::TCC_ADDR_CAP_LOW;
    localparam logic [7:0] A_CMPH = tcc_pkg::TCC_ADDR_CMP_HIGH;
    localparam logic [7:0] A_CMPL = tcc_pkg::TCC_ADDR_CMP_LOW;
    localparam logic [7:0] A_CNTH = tcc_pkg::TCC_ADDR_CNT_HIGH;
    localparam logic [7:0] A_CNTL = tcc_pkg::TCC_ADDR_CNT_LOW;
    logic clk_sys;
    logic rst_b;
    tcc_pkg::tcc_bus_s bus_req;
    logic [7:0] rd_data;
    logic stop_mode;
    logic cap_pin;
    logic cmp2_flag;
    logic src_sel;
    logic cmp_pin;
    logic irq;
    int bad_count = 0;
    int comparisons = 0;
    int cycles = 0;
    logic [7:0] d;
    logic [15:0] c;
    logic [15:0] t;
    logic [15:0] tc;

    tcc_host host (.clk_sys(clk_sys), .bus_req(bus_req), .rd_data(rd_data));
    tcc_timer dut (.clk_sys(clk_sys), .rst_b(rst_b), .bus_req(bus_req), .rd_data(rd_data),
        .stop_mode(stop_mode), .capture_input_pin(cap_pin), .comparator_two_flag(cmp2_flag),
        .capture_source_select(src_sel), .compare_output_pin(cmp_pin), .timer_irq(irq));

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    // ========================================================================
    // Helpers
    // ========================================================================
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == CYCLE_LIMIT) begin
            bad_count++;
            $display("unexpected at %0t: run did not finish", $time);
            report_and_stop();
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input logic [15:0] m, input string msg);
        comparisons++;
        if ((got & m) !== (exp & m)) begin
            bad_count++;
            $display("unexpected at %0t: %s got %h", $time, msg, got);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp, input string msg);
        chk({15'h0000, got}, {15'h0000, exp}, 16'h0001, msg);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m, input string msg);
        host.rd(a, d);
        chk({8'h00, d}, {8'h00, e}, {8'h00, m}, msg);
    endtask

    task automatic rd16(input logic [7:0] ha, input logic [7:0] la);
        host.rd(ha, d);
        c[15:8] = d;
        host.rd(la, d);
        c[7:0] = d;
    endtask

    // Settles just past the edge so registered outputs are read after they update.
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic wait_pin(input logic v, input string msg);
        for (int i = 0; i < 80; i++) begin
            if (cmp_pin === v) break;
            @(posedge clk_sys);
            #1;
        end
        chk_bit(cmp_pin, v, msg);
    endtask

    task automatic set_compare(input logic [15:0] v);
        host.wr(A_CMPH, v[15:8]);
        host.wr(A_CMPL, v[7:0]);
    endtask

    // ========================================================================
    // Tests
    // ========================================================================
    initial begin
        rst_b = 1'b0;
        stop_mode = 1'b0;
        cap_pin = 1'b0;
        cmp2_flag = 1'b0;
        src_sel = 1'b0;
        repeat (16) @(posedge clk_sys);
        rst_b <= 1'b1;
        rd(A_CTL, 8'h00, 8'hE1, "control reset value");
        host.wr(A_CTL, 8'h20);
        cyc(20);
        rd(A_STS, 8'h20, 8'h20, "rollover flag set");
        chk_bit(irq, 1'b1, "rollover irq");
        host.wr(A_CTL, 8'h00);
        cyc(2);
        chk_bit(irq, 1'b0, "rollover irq masked");
        host.wr(A_CTL, 8'h20);
        host.wr(A_STS, 8'h00);
        rd(A_STS, 8'h20, 8'h20, "status write ignored");
        host.rd(A_CNTL, d);
        rd(A_STS, 8'h00, 8'h20, "rollover flag cleared");
        chk_bit(irq, 1'b0, "irq after clear");
        $display("test rollover done");

        host.wr(A_CTL, 8'h41);
        rd16(A_CNTH, A_CNTL);
        t = c + 16'h0006;
        set_compare(t);
        rd(A_CMPH, t[15:8], 8'hFF, "compare high");
        rd(A_CMPL, t[7:0], 8'hFF, "compare low");
        wait_pin(1'b1, "pin high on match");
        host.wr(A_CTL, 8'h40);
        rd16(A_CNTH, A_CNTL);
        t = c + 16'h0006;
        set_compare(t);
        wait_pin(1'b0, "pin low on match with flag set");
        rd(A_STS, 8'h40, 8'h40, "match flag kept");
        chk_bit(irq, 1'b1, "compare irq");
        host.wr(A_CTL, 8'h00);
        cyc(2);
        chk_bit(irq, 1'b0, "compare irq masked");
        host.wr(A_CTL, 8'h41);
        host.wr(A_CMPH, t[15:8]);
        host.rd(A_STS, d);
        host.wr(A_CMPL, t[7:0]);
        rd(A_STS, 8'h00, 8'h40, "match flag cleared");
        chk_bit(irq, 1'b0, "irq after match clear");
        rd16(A_CNTH, A_CNTL);
        tc = c + 16'h0006;
        set_compare(tc);
        host.wr(A_CMPH, tc[15:8]);
        cyc(60);
        chk_bit(cmp_pin, 1'b0, "pin held while inhibited");
        rd(A_STS, 8'h00, 8'h40, "no flag while inhibited");
        $display("test compare done");

        host.wr(A_CTL, 8'h82);
        cap_pin <= 1'b1;
        cyc(6);
        rd(A_STS, 8'h80, 8'h80, "capture on rising");
        chk_bit(irq, 1'b1, "capture irq");
        host.rd(A_CAPH, d);
        host.rd(A_CAPL, d);
        rd(A_STS, 8'h00, 8'h80, "capture flag cleared");
        chk_bit(irq, 1'b0, "irq after capture clear");
        cap_pin <= 1'b0;
        cyc(6);
        rd(A_STS, 8'h00, 8'h80, "falling ignored");
        host.wr(A_CTL, 8'h80);
        cap_pin <= 1'b1;
        cyc(6);
        rd(A_STS, 8'h00, 8'h80, "rising ignored");
        cap_pin <= 1'b0;
        cyc(6);
        rd(A_STS, 8'h80, 8'h80, "capture on falling");
        host.rd(A_CAPL, d);
        src_sel <= 1'b1;
        host.wr(A_CTL, 8'h82);
        cmp2_flag <= 1'b1;
        cyc(4);
        rd(A_STS, 8'h80, 8'h80, "comparator capture");
        host.rd(A_CAPL, d);
        $display("test capture done");

        cmp2_flag <= 1'b0;
        stop_mode <= 1'b1;
        cyc(2);
        rd16(A_CNTH, A_CNTL);
        t = c;
        cyc(8);
        rd16(A_CNTH, A_CNTL);
        chk(c, t, 16'hFFFF, "counter frozen in stop");
        cmp2_flag <= 1'b1;
        cyc(6);
        rd(A_STS, 8'h00, 8'h80, "no flag during stop");
        stop_mode <= 1'b0;
        cyc(4);
        rd(A_STS, 8'h80, 8'h80, "flag after wakeup");
        rd16(A_CAPH, A_CAPL);
        chk(c, t + 16'h0001, 16'hFFFF, "captured value");
        cmp2_flag <= 1'b0;
        stop_mode <= 1'b1;
        cyc(2);
        cmp2_flag <= 1'b1;
        cyc(4);
        rst_b <= 1'b0;
        cyc(2);
        rst_b <= 1'b1;
        stop_mode <= 1'b0;
        rd16(A_CNTH, A_CNTL);
        chk(c, tcc_pkg::TCC_CNT_RESET, 16'hFFFF, "counter after reset");
        rd(A_STS, 8'h00, 8'hE0, "flags across reset");
        rd(A_CTL, 8'h02, 8'hE3, "edge select kept");
        rd(A_CMPH, tc[15:8], 8'hFF, "compare high kept");
        rd(A_CMPL, tc[7:0], 8'hFF, "compare low kept");
        rd(8'h00, 8'h00, 8'hFF, "unmapped read");
        host.wr(A_CTL, 8'hFF);
        rd(A_CTL, 8'hE3, 8'hFF, "control readback");
        $display("test stop and reset done");
        report_and_stop();
    end
endmodule

`default_nettype wire
